//--- rtl/rspt_core.sv
// reset status flags, configuration watch and power-up timer
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// - brown-out or power-on clears brownout_flag
// - low-power brown-out rearms power-on, clears brownout_flag too
// - compare config against shadows every cycle in run phase
// - mismatch clears cfg_mismatch_flag, power-on and brown-out set it
// - mismatch acts as pin reset, reloads config
// - timer runs only when powerup_timer_en set
// - 13-bit timer on slow oscillator, 2048 ticks
// - hold reset while timer counts
// - timer starts after power-on pulse ends
// - timer runs under low pin; expired starts
// - undefined registers untouched by non-power resets
// - watchdog wake-up leaves registers unchanged
// - pin reset in run mode sets timeout
// - pin reset in sleep: timeout 1, powerdown 0
// - pin reset at full power keeps flags
// - stack full reset sets stack_full_flag
// - underflow flags; resets only when enabled
// - watchdog in run clears timeout, vector zero
// - watchdog in sleep clears both, pc plus two
// - interrupt wake clears powerdown, pc plus two
// - interrupt wake with enable loads vector
// - power-on clears poweron_flag and brownout_flag
// - reset instruction clears reset_instr_flag
module rspt_core #(
    parameter int POWERUP_TIMER_COUNT = 2048
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_reset_pin_n,
    input wire logic slow_internal_osc,
    input wire rspt_pkg::rspt_event_s events,
    input wire rspt_pkg::rspt_pmode_e pmode,
    input wire logic high_global_int_enable,
    input wire logic low_global_int_enable,
    input wire logic high_priority_irq,
    input wire logic [31:0] cfg_words,
    input wire logic [31:0] cfg_shadow,
    input wire logic [31:0] cfg_nv_words,
    input wire logic [20:0] pc_now,
    output logic core_reset_n,
    output logic cfg_reload,
    output logic cfg_mismatch_reset,
    output logic [20:0] pc_load,
    output logic pc_load_valid
);
    rspt_pkg::rspt_state_s st;
    rspt_pkg::rspt_state_s next_st;
    logic [rspt_pkg::CFG_WORDS-1:0] pair_bad;
    logic mismatch;

    // ------------------------------------------------------------
    // configuration watch
    // ------------------------------------------------------------
    // shadows hold complements; one comparator per byte
    genvar gi;
    generate
        for (gi = 0; gi < rspt_pkg::CFG_WORDS; gi++) begin : g_cmp
            assign pair_bad[gi] = (cfg_words[gi*8 +: 8]
                                   != ~cfg_shadow[gi*8 +: 8]);
        end
    endgenerate
    // no check while config is being reloaded
    assign mismatch = |pair_bad && st.phase == rspt_pkg::RSPT_ST_RUN;

    // ------------------------------------------------------------
    // apb slave: zero wait states
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign addr_ok = paddr == rspt_pkg::ADDR_RESET_CONTROL_REG
                     || paddr == rspt_pkg::ADDR_STAT
                     || paddr == rspt_pkg::ADDR_CFG
                     || paddr == rspt_pkg::ADDR_CMD;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic osc_rise;
    logic powerup_timer_on;
    logic pin_reset;
    logic hard_reset;
    logic stack_underflow_flag_reset;
    logic cmd_reset;
    always_comb begin
        next_st = st;
        next_st.reload = 1'b0;
        next_st.pc_load_valid = 1'b0;
        // three-stage synchronisers; second and third must agree
        next_st.pin_sync = {st.pin_sync[1:0], external_reset_pin_n};
        if (st.pin_sync[1] == st.pin_sync[2]) begin
            next_st.pin_level = st.pin_sync[2];
        end
        next_st.osc_sync = {st.osc_sync[1:0], slow_internal_osc};
        if (st.osc_sync[1] == st.osc_sync[2]) begin
            next_st.osc_level = st.osc_sync[2];
        end
        osc_rise = next_st.osc_level && !st.osc_level;
        powerup_timer_on = st.cfg[rspt_pkg::BIT_POWERUP_TIMER_EN];
        pin_reset = !st.pin_level;
        cmd_reset = wr_en && paddr == rspt_pkg::ADDR_CMD
                    && pwdata[rspt_pkg::BIT_CMD_RESET];
        stack_underflow_flag_reset = events.stack_underflow
                       && st.cfg[rspt_pkg::BIT_STACK_OVERFLOW_RESET_EN];
        hard_reset = 1'b0;

        // software writes first so hardware events win over them
        if (wr_en && paddr == rspt_pkg::ADDR_RESET_CONTROL_REG) begin
            next_st.reset_control_reg[rspt_pkg::BIT_BOR] = pwdata[rspt_pkg::BIT_BOR];
            next_st.reset_control_reg[rspt_pkg::BIT_POR] = pwdata[rspt_pkg::BIT_POR];
            next_st.reset_control_reg[rspt_pkg::BIT_RI] = pwdata[rspt_pkg::BIT_RI];
            next_st.reset_control_reg[rspt_pkg::BIT_CM] = pwdata[rspt_pkg::BIT_CM];
        end
        if (wr_en && paddr == rspt_pkg::ADDR_STAT) begin
            next_st.stack_full_flag = pwdata[rspt_pkg::BIT_STACK_FULL_FLAG];
            next_st.stack_underflow_flag = pwdata[rspt_pkg::BIT_STACK_UNDERFLOW_FLAG];
        end
        if (wr_en && paddr == rspt_pkg::ADDR_CFG) begin
            next_st.cfg = pwdata[7:0];
        end
        if (wr_en && paddr == rspt_pkg::ADDR_CMD) begin
            if (pwdata[rspt_pkg::BIT_CMD_SLEEP]) begin
                next_st.reset_control_reg[rspt_pkg::BIT_TO] = 1'b1;
                next_st.reset_control_reg[rspt_pkg::BIT_PD] = 1'b0;
            end
            if (pwdata[rspt_pkg::BIT_CMD_CLRWDT]) begin
                next_st.reset_control_reg[rspt_pkg::BIT_TO] = 1'b1;
                next_st.reset_control_reg[rspt_pkg::BIT_PD] = 1'b1;
            end
        end

        // events
        if (events.poweron || events.lowpower_brownout) begin
            // low-power brown-out loads the power-on value, clearing brownout_flag
            next_st.reset_control_reg = rspt_pkg::RESET_CONTROL_REG_POR_VALUE;
            next_st.stack_full_flag = 1'b0;
            next_st.stack_underflow_flag = 1'b0;
            next_st.phase = rspt_pkg::RSPT_ST_POR;
            next_st.powerup_timer_cnt = '0;
        end else if (events.brownout) begin
            next_st.reset_control_reg[rspt_pkg::BIT_BOR] = 1'b0;
            next_st.reset_control_reg[rspt_pkg::BIT_CM] = 1'b1;
            next_st.reset_control_reg[rspt_pkg::BIT_RI] = 1'b1;
            next_st.reset_control_reg[rspt_pkg::BIT_TO] = 1'b1;
            next_st.reset_control_reg[rspt_pkg::BIT_PD] = 1'b1;
            next_st.phase = rspt_pkg::RSPT_ST_POR;
            next_st.powerup_timer_cnt = '0;
        end else if (st.phase == rspt_pkg::RSPT_ST_RUN) begin
            if (mismatch) begin
                next_st.reset_control_reg[rspt_pkg::BIT_CM] = 1'b0;
                hard_reset = 1'b1;
            end
            if (cmd_reset) begin
                next_st.reset_control_reg[rspt_pkg::BIT_RI] = 1'b0;
                hard_reset = 1'b1;
            end
            if (pin_reset) begin
                hard_reset = 1'b1;
                case (pmode)
                    rspt_pkg::RSPT_RUN_PM: begin
                        next_st.reset_control_reg[rspt_pkg::BIT_TO] = 1'b1;
                    end
                    rspt_pkg::RSPT_IDLE_SLEEP: begin
                        next_st.reset_control_reg[rspt_pkg::BIT_TO] = 1'b1;
                        next_st.reset_control_reg[rspt_pkg::BIT_PD] = 1'b0;
                    end
                    default: begin
                    end
                endcase
            end
            if (events.stack_full && st.cfg[rspt_pkg::BIT_STACK_OVERFLOW_RESET_EN]) begin
                next_st.stack_full_flag = 1'b1;
                hard_reset = 1'b1;
            end
            if (events.stack_underflow) begin
                next_st.stack_underflow_flag = 1'b1;
                hard_reset = hard_reset || stack_underflow_flag_reset;
            end
            if (events.wdt_timeout) begin
                next_st.reset_control_reg[rspt_pkg::BIT_TO] = 1'b0;
                if (pmode == rspt_pkg::RSPT_IDLE_SLEEP) begin
                    // wake, not reset: registers untouched
                    next_st.reset_control_reg[rspt_pkg::BIT_PD] = 1'b0;
                    next_st.pc_load = 21'(pc_now + rspt_pkg::PC_STEP);
                    next_st.pc_load_valid = 1'b1;
                end else begin
                    hard_reset = 1'b1;
                end
            end else if (events.wake_irq && pmode != rspt_pkg::RSPT_RUN_FULL) begin
                next_st.reset_control_reg[rspt_pkg::BIT_PD] = 1'b0;
                next_st.pc_load_valid = 1'b1;
                if (high_global_int_enable || low_global_int_enable) begin
                    next_st.pc_load = high_priority_irq
                        ? rspt_pkg::VEC_HIGH : rspt_pkg::VEC_LOW;
                end else begin
                    next_st.pc_load = 21'(pc_now + rspt_pkg::PC_STEP);
                end
            end
            if (hard_reset) begin
                next_st.phase = rspt_pkg::RSPT_ST_HOLD;
                next_st.reload = 1'b1;
                next_st.pc_load_valid = 1'b0;
            end
        end else begin
            // ------------------------------------------------------------
            // startup sequence
            // ------------------------------------------------------------
            case (st.phase)
                rspt_pkg::RSPT_ST_POR: begin
                    // power-on pulse ends on this cycle; reload config
                    next_st.reload = 1'b1;
                    next_st.powerup_timer_cnt = '0;
                    next_st.phase = powerup_timer_on ? rspt_pkg::RSPT_ST_POWERUP_TIMER
                                            : rspt_pkg::RSPT_ST_HOLD;
                end
                rspt_pkg::RSPT_ST_POWERUP_TIMER: begin
                    // counts regardless of pin level
                    if (osc_rise) begin
                        next_st.powerup_timer_cnt = 13'(st.powerup_timer_cnt + 13'h0001);
                    end
                    if (st.powerup_timer_cnt >= 13'(POWERUP_TIMER_COUNT)) begin
                        next_st.phase = rspt_pkg::RSPT_ST_HOLD;
                    end
                end
                rspt_pkg::RSPT_ST_HOLD: begin
                    if (!pin_reset) begin
                        next_st.phase = rspt_pkg::RSPT_ST_RELEASE;
                    end
                end
                rspt_pkg::RSPT_ST_RELEASE: begin
                    next_st.pc_load = rspt_pkg::RESET_VECTOR;
                    next_st.pc_load_valid = 1'b1;
                    next_st.phase = rspt_pkg::RSPT_ST_RUN;
                end
                default: begin
                    next_st.phase = rspt_pkg::RSPT_ST_RUN;
                end
            endcase
        end

        if (st.reload) begin
            next_st.cfg = cfg_nv_words[7:0];
        end

        // read data registered in the setup phase
        if (rd_en) begin
            case (paddr)
                rspt_pkg::ADDR_RESET_CONTROL_REG: next_st.prdata = {26'h0, st.reset_control_reg};
                rspt_pkg::ADDR_STAT: next_st.prdata = {28'h0,
                    st.phase == rspt_pkg::RSPT_ST_POWERUP_TIMER,
                    st.phase != rspt_pkg::RSPT_ST_RUN,
                    st.stack_underflow_flag, st.stack_full_flag};
                rspt_pkg::ADDR_CFG: next_st.prdata = {24'h0, st.cfg};
                default: next_st.prdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // flags untouched by non-power resets live here, not in the
    // cpu-side reset domain
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{phase: rspt_pkg::RSPT_ST_POR,
                    reset_control_reg: rspt_pkg::RESET_CONTROL_REG_POR_VALUE,
                    cfg: rspt_pkg::CFG_RESET,
                    pin_sync: 3'h0,
                    pc_load: rspt_pkg::RESET_VECTOR,
                    default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign core_reset_n = st.phase == rspt_pkg::RSPT_ST_RUN;
    assign cfg_reload = st.reload;
    assign cfg_mismatch_reset = mismatch;
    assign pc_load = st.pc_load;
    assign pc_load_valid = st.pc_load_valid;
    assign prdata = st.prdata;
endmodule : rspt_core

//--- shared/rspt_pkg.sv
// package: constants, register map and state types of the reset status block
package rspt_pkg;
    // apb register byte offsets
    localparam logic [7:0] ADDR_RESET_CONTROL_REG = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_CFG = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0c;
    // reset_control_reg bit positions
    localparam int BIT_BOR = 0;
    localparam int BIT_POR = 1;
    localparam int BIT_PD = 2;
    localparam int BIT_TO = 3;
    localparam int BIT_RI = 4;
    localparam int BIT_CM = 5;
    // status register bit positions
    localparam int BIT_STACK_FULL_FLAG = 0;
    localparam int BIT_STACK_UNDERFLOW_FLAG = 1;
    localparam int BIT_INRST = 2;
    localparam int BIT_POWERUP_TIMER_RUN = 3;
    // cfg register bit positions (config_word_2_low copy)
    localparam int BIT_POWERUP_TIMER_EN = 0;
    localparam int BIT_STACK_OVERFLOW_RESET_EN = 1;
    // command register bits
    localparam int BIT_CMD_RESET = 0;
    localparam int BIT_CMD_SLEEP = 1;
    localparam int BIT_CMD_CLRWDT = 2;
    // reset values
    localparam logic [5:0] RESET_CONTROL_REG_POR_VALUE = 6'h3c;
    localparam logic [7:0] CFG_RESET = 8'h03;
    localparam logic [20:0] RESET_VECTOR = 21'h000000;
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW = 21'h000018;
    localparam logic [20:0] PC_STEP = 21'h000002;
    // power-up timer: 13-bit counter, 2048 slow ticks of 32 us
    localparam int POWERUP_TIMER_BITS = 13;
    localparam logic [12:0] POWERUP_TIMER_TICKS = 13'h0800;
    localparam int SLOW_PERIOD_US = 32;
    localparam int MCLK_MHZ = 10;
    localparam int CFG_WORDS = 4;

    typedef enum logic [1:0] {
        RSPT_RUN_FULL,
        RSPT_RUN_PM,
        RSPT_IDLE_SLEEP
    } rspt_pmode_e;

    typedef enum logic [2:0] {
        RSPT_ST_POR,
        RSPT_ST_POWERUP_TIMER,
        RSPT_ST_HOLD,
        RSPT_ST_RELEASE,
        RSPT_ST_RUN
    } rspt_phase_e;

    typedef struct packed {
        logic poweron;
        logic brownout;
        logic lowpower_brownout;
        logic wdt_timeout;
        logic stack_full;
        logic stack_underflow;
        logic reset_instr;
        logic wake_irq;
    } rspt_event_s;

    typedef struct packed {
        rspt_phase_e phase;
        logic [5:0] reset_control_reg;
        logic stack_full_flag;
        logic stack_underflow_flag;
        logic [7:0] cfg;
        logic [12:0] powerup_timer_cnt;
        logic [2:0] pin_sync;
        logic pin_level;
        logic [2:0] osc_sync;
        logic osc_level;
        logic reload;
        logic [20:0] pc_load;
        logic pc_load_valid;
        logic [31:0] prdata;
    } rspt_state_s;
endpackage : rspt_pkg

//--- test/rspt_core_assertions.sv
// checker: timing relations at the ports of the reset status block
`timescale 1ns/1ps
module rspt_core_chk #(
    parameter int POWERUP_TIMER_COUNT = 2048
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic external_reset_pin_n,
    input wire rspt_pkg::rspt_event_s events,
    input wire rspt_pkg::rspt_pmode_e pmode,
    input wire logic high_global_int_enable,
    input wire logic low_global_int_enable,
    input wire logic high_priority_irq,
    input wire logic [31:0] cfg_words,
    input wire logic [31:0] cfg_shadow,
    input wire logic [20:0] pc_now,
    input wire logic core_reset_n,
    input wire logic cfg_reload,
    input wire logic cfg_mismatch_reset,
    input wire logic [20:0] pc_load,
    input wire logic pc_load_valid
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_bor_resets: assert property (
        events.brownout |-> ##[1:3] !core_reset_n)
        else $error("brown-out did not reset the core");
    chk_cm_level: assert property (
        core_reset_n && cfg_words != ~cfg_shadow |-> cfg_mismatch_reset)
        else $error("mismatch not flagged while running");
    chk_cm_reload: assert property (
        cfg_mismatch_reset |-> ##[0:4] cfg_reload)
        else $error("no configuration reload after mismatch");
    chk_pin_resets: assert property (
        core_reset_n && !external_reset_pin_n |-> ##[1:5] !core_reset_n)
        else $error("low pin did not reset the core");
    chk_release_pin: assert property (
        $rose(core_reset_n) |->
            external_reset_pin_n && $past(external_reset_pin_n, 2))
        else $error("core released while pin low");
    chk_restart_pc: assert property (
        $rose(core_reset_n) |-> (pc_load_valid || $past(pc_load_valid))
            && pc_load == rspt_pkg::RESET_VECTOR)
        else $error("restart without reset vector");
    chk_wdt_sleep_pc: assert property (
        core_reset_n && events.wdt_timeout &&
            pmode == rspt_pkg::RSPT_IDLE_SLEEP |=> core_reset_n &&
            pc_load_valid && pc_load == $past(pc_now) + rspt_pkg::PC_STEP)
        else $error("watchdog wake pc wrong");
    chk_irq_vector: assert property (
        core_reset_n && events.wake_irq &&
            pmode != rspt_pkg::RSPT_RUN_FULL &&
            (high_global_int_enable || low_global_int_enable)
            |=> pc_load_valid && pc_load == ($past(high_priority_irq) ?
            rspt_pkg::VEC_HIGH : rspt_pkg::VEC_LOW))
        else $error("interrupt wake vector wrong");
endmodule : rspt_core_chk

bind rspt_core rspt_core_chk #(.POWERUP_TIMER_COUNT(POWERUP_TIMER_COUNT)) i_rspt_core_chk (
    .mclk(mclk), .reset_n(reset_n),
    .external_reset_pin_n(external_reset_pin_n), .events(events),
    .pmode(pmode), .high_global_int_enable(high_global_int_enable),
    .low_global_int_enable(low_global_int_enable),
    .high_priority_irq(high_priority_irq), .cfg_words(cfg_words),
    .cfg_shadow(cfg_shadow), .pc_now(pc_now), .core_reset_n(core_reset_n),
    .cfg_reload(cfg_reload), .cfg_mismatch_reset(cfg_mismatch_reset),
    .pc_load(pc_load), .pc_load_valid(pc_load_valid));

//--- test/rspt_core_bench.sv
// bench: scenarios for the reset status block
`timescale 1ns/1ps
module rspt_core_bench;
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pin_n, osc, pin_req, hi_en, lo_en, hprio, crst_n, reload, mm, pcv;
    rspt_pkg::rspt_event_s events;
    rspt_pkg::rspt_pmode_e pmode;
    logic [31:0] cfg_words, cfg_shadow;
    logic [20:0] pc_now, pc_load, last_pc;
    int errors, n_compared, cycles;
    rspt_core #(.POWERUP_TIMER_COUNT(4)) i_rspt_core (.mclk(mclk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_reset_pin_n(pin_n), .slow_internal_osc(osc),
        .events(events), .pmode(pmode), .high_global_int_enable(hi_en),
        .low_global_int_enable(lo_en), .high_priority_irq(hprio),
        .cfg_words(cfg_words), .cfg_shadow(cfg_shadow), .cfg_nv_words(32'h3),
        .pc_now(pc_now), .core_reset_n(crst_n), .cfg_reload(reload),
        .cfg_mismatch_reset(mm), .pc_load(pc_load), .pc_load_valid(pcv));
    rspt_far_side i_rspt_far_side (.mclk(mclk), .pin_req(pin_req),
        .external_reset_pin_n(pin_n), .slow_internal_osc(osc));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("register", exp, rd);
    endtask : rd_chk
    task automatic wait_run();
        int n;
        n = 0;
        repeat (4) @(posedge mclk);
        while (crst_n !== 1'b1 && n < 600) begin
            @(posedge mclk);
            n++;
        end
        check("core_reset_n", 32'h1, {31'h0, crst_n});
    endtask : wait_run
    // mask order: poweron brownout lpbor wdt stack_full_flag stack_underflow_flag instr wake
    task automatic fire(input logic [7:0] m, input logic [5:0] pre,
            input logic [5:0] exp, input logic rst);
        apb(1'b1, rspt_pkg::ADDR_RESET_CONTROL_REG, {26'h0, pre});
        events <= rspt_pkg::rspt_event_s'(m);
        @(posedge mclk);
        events <= '0;
        @(posedge mclk);
        if (rst) wait_run();
        else repeat (2) @(posedge mclk);
        rd_chk(rspt_pkg::ADDR_RESET_CONTROL_REG, {26'h0, exp});
    endtask : fire
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_powerup();
        repeat (2) @(posedge mclk);
        apb(1'b0, rspt_pkg::ADDR_STAT, 32'h0);
        check("in reset", 32'h4, rd & 32'h4);
        wait_run();
        rd_chk(rspt_pkg::ADDR_RESET_CONTROL_REG, 32'h3c);
        rd_chk(rspt_pkg::ADDR_CFG, 32'h3);
    endtask : t_powerup
    task automatic t_late();
        int n;
        n = 0;
        pin_req <= 1'b1;
        reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (200) @(posedge mclk);
        check("held", 32'h0, {31'h0, crst_n});
        pin_req <= 1'b0;
        while (crst_n !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        check("prompt start", 32'h1, {31'h0, n <= 8});
    endtask : t_late
    task automatic t_power();
        fire(8'h40, 6'h3f, 6'h3e, 1'b1);
        fire(8'h20, 6'h3f, 6'h3c, 1'b1);
        apb(1'b1, rspt_pkg::ADDR_CMD, 32'h1);
        wait_run();
        rd_chk(rspt_pkg::ADDR_RESET_CONTROL_REG, 32'h2c);
    endtask : t_power
    task automatic t_mismatch();
        apb(1'b1, rspt_pkg::ADDR_RESET_CONTROL_REG, 32'h3f);
        cfg_shadow <= cfg_words;
        // look mid-cycle: the reset it raises drops mm at the next edge
        @(negedge mclk);
        check("mismatch", 32'h1, {31'h0, mm});
        @(posedge mclk);
        cfg_shadow <= ~cfg_words;
        wait_run();
        rd_chk(rspt_pkg::ADDR_RESET_CONTROL_REG, 32'h1f);
    endtask : t_mismatch
    task automatic t_pin();
        logic [5:0] exp [3] = '{6'h37, 6'h3f, 6'h3b};
        for (int i = 0; i < 3; i++) begin
            // timeout flag is read-only: a watchdog reset clears it
            apb(1'b1, rspt_pkg::ADDR_CMD, 32'h4);
            fire(8'h10, 6'h3f, 6'h37, 1'b1);
            pmode <= rspt_pkg::rspt_pmode_e'(i);
            pin_req <= 1'b1;
            repeat (10) @(posedge mclk);
            pin_req <= 1'b0;
            wait_run();
            rd_chk(rspt_pkg::ADDR_RESET_CONTROL_REG, {26'h0, exp[i]});
            check("pc", 32'h0, {11'h0, last_pc});
            pmode <= rspt_pkg::RSPT_RUN_FULL;
        end
    endtask : t_pin
    task automatic t_wdt();
        apb(1'b1, rspt_pkg::ADDR_CMD, 32'h4);
        fire(8'h10, 6'h3f, 6'h37, 1'b1);
        pmode <= rspt_pkg::RSPT_IDLE_SLEEP;
        fire(8'h10, 6'h3f, 6'h33, 1'b0);
        check("pc", 32'h102, {11'h0, last_pc});
    endtask : t_wdt
    task automatic t_wake();
        logic [20:0] exp [3] = '{21'h102, 21'h8, 21'h18};
        pmode <= rspt_pkg::RSPT_RUN_PM;
        apb(1'b1, rspt_pkg::ADDR_CMD, 32'h4);
        for (int i = 0; i < 3; i++) begin
            hi_en <= (i == 1);
            lo_en <= (i == 2);
            hprio <= (i == 1);
            fire(8'h01, 6'h3f, 6'h3b, 1'b0);
            check("pc", {11'h0, exp[i]}, {11'h0, last_pc});
        end
        pmode <= rspt_pkg::RSPT_RUN_FULL;
    endtask : t_wake
    task automatic t_stack();
        apb(1'b1, rspt_pkg::ADDR_CFG, 32'h1);
        fire(8'h04, 6'h3f, 6'h3b, 1'b0);
        check("running", 32'h1, {31'h0, crst_n});
        rd_chk(rspt_pkg::ADDR_STAT, 32'h2);
        apb(1'b1, rspt_pkg::ADDR_STAT, 32'h0);
        apb(1'b1, rspt_pkg::ADDR_CFG, 32'h3);
        fire(8'h08, 6'h3f, 6'h3b, 1'b1);
        rd_chk(rspt_pkg::ADDR_STAT, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        check("pslverr", 32'h1, {31'h0, err});
    endtask : t_stack
    // ----------------------------------------
    // clock, timeout and main sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (pcv === 1'b1) last_pc <= pc_load;
        if (cycles == 30000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        {psel, penable, pwrite, pin_req, hi_en, lo_en, hprio} = '0;
        {paddr, pwdata, events, last_pc} = '0;
        pmode = rspt_pkg::RSPT_RUN_FULL;
        cfg_words = 32'h5a5a0f03;
        cfg_shadow = ~32'h5a5a0f03;
        pc_now = 21'h100;
        reset_n = 1'b0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        t_powerup();
        t_late();
        t_power();
        t_mismatch();
        t_pin();
        t_wdt();
        t_wake();
        t_stack();
        print_verdict();
    end
endmodule : rspt_core_bench

//--- test/rspt_far_side.sv
// far side model: reset pin and free-running slow oscillator
`timescale 1ns/1ps
module rspt_far_side (
    input wire logic mclk,
    input wire logic pin_req,
    output logic external_reset_pin_n,
    output logic slow_internal_osc
);
    logic [2:0] div = 3'h0;
    // oscillator runs free; 16 mclk periods keeps the timer run short
    always @(posedge mclk) begin
        div <= div + 3'h1;
        if (div == 3'h7) begin
            slow_internal_osc <= ~slow_internal_osc;
        end
    end
    initial slow_internal_osc = 1'b0;
    assign external_reset_pin_n = ~pin_req;
endmodule : rspt_far_side
